/* src/sleep_wake_ctrl.sv */
// sleep entry, wake-up and peripheral interrupt flag control
`timescale 1ns/100ps
module sleep_wake_ctrl
   import sleep_wake_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // apb
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [11:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // core side
   input  wire logic             sleepExec,
   input  wire logic             watchdogClearInstr,
   input  wire logic             watchdogSleepEnable,
   input  wire logic             externalIrq,
   input  wire logic             watchdogTimeout,
   input  wire logic             portHoldNone,
   output logic                  coreClockEnable,
   output logic                  wakeResume,
   output logic                  vectorRequest,
   output logic      [15:0]      vectorAddress,
   output logic                  watchdogClear,
   output logic                  regulatorLowPower,
   output logic                  portHold,
   output logic                  lowFreqOscRun,
   output logic                  secondaryOscRun,
   // peripheral flag events
   input  wire logic [REG_W-1:0] eventsA,
   input  wire logic [REG_W-1:0] eventsB
);
   logic [REG_W-1:0] ctrl, enA, enB, regCtl;
   logic [REG_W-1:0] flagsA, flagsB;
   logic             powerDownN, timeoutN;
   pwr_state_e       state, next_state;
   logic             wrCtrl, wrEnA, wrEnB, wrFlagA, wrFlagB, wrReg, hitAny;

   apb_reg_port u_port (
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .wrCtrl  (wrCtrl),
      .wrEnA   (wrEnA),
      .wrEnB   (wrEnB),
      .wrFlagA (wrFlagA),
      .wrFlagB (wrFlagB),
      .wrReg   (wrReg),
      .hitAny  (hitAny)
   );

   irq_flag_bank u_flags_a (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .setEvent (eventsA),
      .implMask (FLAGS_A_IMPL),
      .swMask   (FLAGS_A_SW_MASK),
      .swWrite  (wrFlagA),
      .swData   (pwdata[REG_W-1:0]),
      .flags    (flagsA)
   );

   irq_flag_bank u_flags_b (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .setEvent (eventsB),
      .implMask (FLAGS_B_IMPL),
      .swMask   (FLAGS_B_SW_MASK),
      .swWrite  (wrFlagB),
      .swData   (pwdata[REG_W-1:0]),
      .flags    (flagsB)
   );

   // interrupt request terms
   wire globalEn   = ctrl[CTRL_GIE_BIT];
   wire periphEn   = ctrl[CTRL_PERIPHERAL_IRQ_ENABLE_BIT];
   wire periphPend = |(flagsA & enA) | |(flagsB & enB);
   wire wakeIrq    = periphPend | externalIrq;
   wire vectorPend = periphPend & periphEn & globalEn;

   // sleep sequencing
   wire sleepNop   = (state == ST_RUN) & sleepExec & wakeIrq & ~globalEn;
   wire sleepEnter = (state == ST_RUN) & sleepExec & ~sleepNop;
   wire wakeNow    = (state == ST_SLEEP) & (wakeIrq | watchdogTimeout);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_RUN: begin
            if (sleepEnter) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (wakeNow) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_RUN;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // status bits: both read one after reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         powerDownN <= 1'b1;
         timeoutN   <= 1'b1;
      end else if (ce) begin
         if (sleepEnter) begin
            powerDownN <= 1'b0;
            timeoutN   <= 1'b1;
         end else if (watchdogClearInstr) begin
            powerDownN <= 1'b1;
            timeoutN   <= 1'b1;
         end else if (state == ST_RUN & watchdogTimeout) begin
            timeoutN <= 1'b0;
         end
      end
   end

   // software registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl   <= FLAG_RESET;
         enA    <= FLAG_RESET;
         enB    <= FLAG_RESET;
         regCtl <= REGULATOR_RESET;
      end else if (ce) begin
         if (wrCtrl) begin
            ctrl <= pwdata[REG_W-1:0] & CTRL_MASK;
         end
         if (wrEnA) begin
            enA <= pwdata[REG_W-1:0];
         end
         if (wrEnB) begin
            enB <= pwdata[REG_W-1:0] & FLAGS_B_IMPL;
         end
         if (wrReg) begin
            regCtl <= (pwdata[REG_W-1:0] & REGULATOR_WMASK) | REGULATOR_RESET;
         end
      end
   end

   // read mux
   wire [REG_W-1:0] statusRd = REG_W'({timeoutN, powerDownN, 2'b00, state == ST_SLEEP});
   wire [REG_W-1:0] rdSel =
        (paddr == ADDR_CORE_CTRL) ? ctrl   :
        (paddr == ADDR_ENABLE_A)  ? enA    :
        (paddr == ADDR_ENABLE_B)  ? enB    :
        (paddr == ADDR_FLAGS_A)   ? flagsA :
        (paddr == ADDR_FLAGS_B)   ? flagsB :
        (paddr == ADDR_REGULATOR) ? regCtl :
        (paddr == ADDR_STATUS)    ? statusRd : 8'h00;
   wire setupRd  = psel & ~penable;

   // bus answer registered during setup so access phase sees it at once
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= setupRd;
         pslverr <= setupRd & ~hitAny;
         if (setupRd & ~pwrite) begin
            prdata <= {24'h000000, rdSel};
         end
      end
   end

   // core side outputs
   wire sleepNext = (next_state == ST_SLEEP);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         coreClockEnable   <= 1'b1;
         wakeResume        <= 1'b0;
         vectorRequest     <= 1'b0;
         vectorAddress     <= 16'h0000;
         watchdogClear     <= 1'b0;
         regulatorLowPower <= 1'b0;
         portHold          <= 1'b0;
         lowFreqOscRun     <= 1'b1;
         secondaryOscRun   <= 1'b1;
      end else if (ce) begin
         coreClockEnable   <= ~sleepNext;
         lowFreqOscRun     <= 1'b1;
         secondaryOscRun   <= 1'b1;
         portHold          <= sleepNext & ~portHoldNone;
         regulatorLowPower <= sleepNext & regCtl[REG_VPM_BIT];
         wakeResume        <= wakeNow;
         watchdogClear     <= sleepEnter | wakeNow | watchdogClearInstr;
         // vector after the prefetched instruction has run
         vectorRequest     <= (state != ST_SLEEP) & vectorPend & ~sleepEnter;
         vectorAddress     <= IRQ_VECTOR;
      end
   end
endmodule

/* pkg/sleep_wake_pkg.sv */
// constants for the sleep, wake and peripheral flag block
package sleep_wake_pkg;
   localparam int REG_W = 8;
   // register byte addresses on the bus
   localparam logic [11:0] ADDR_CORE_CTRL  = 12'h000;
   localparam logic [11:0] ADDR_ENABLE_A   = 12'h004;
   localparam logic [11:0] ADDR_ENABLE_B   = 12'h008;
   localparam logic [11:0] ADDR_FLAGS_A    = 12'h00c;
   localparam logic [11:0] ADDR_FLAGS_B    = 12'h010;
   localparam logic [11:0] ADDR_REGULATOR  = 12'h014;
   localparam logic [11:0] ADDR_STATUS     = 12'h018;
   // core_irq_control fields
   localparam int CTRL_GIE_BIT  = 7;
   localparam int CTRL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam logic [7:0] CTRL_MASK = 8'hc0;
   // flag register A: serial rx (5) and tx (4) are hardware-owned
   localparam logic [7:0] FLAGS_A_SW_MASK = 8'hcf;
   localparam logic [7:0] FLAGS_A_IMPL    = 8'hff;
   // flag register B: bits 7, 3, 0
   localparam logic [7:0] FLAGS_B_IMPL    = 8'h89;
   localparam logic [7:0] FLAGS_B_SW_MASK = 8'h89;
   localparam logic [7:0] FLAG_RESET      = 8'h00;
   // regulator control: bit 1 power select, bit 0 reserved reads one
   localparam int REG_VPM_BIT = 1;
   localparam logic [7:0] REGULATOR_RESET = 8'h01;
   localparam logic [7:0] REGULATOR_WMASK = 8'h02;
   // status fields
   localparam int STAT_TO_BIT    = 4;
   localparam int STAT_PD_BIT    = 3;
   localparam int STAT_SLEEP_BIT = 0;
   localparam logic [15:0] IRQ_VECTOR = 16'h0004;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} pwr_state_e;
endpackage

/* src/irq_flag_bank.sv */
// one bank of eight sticky interrupt flags with software write access
`timescale 1ns/100ps
module irq_flag_bank
   import sleep_wake_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic [REG_W-1:0] setEvent,
   input  wire logic [REG_W-1:0] implMask,
   input  wire logic [REG_W-1:0] swMask,
   input  wire logic             swWrite,
   input  wire logic [REG_W-1:0] swData,
   output logic      [REG_W-1:0] flags
);
   logic [REG_W-1:0] next_flags;
   genvar i;
   generate
      for (i = 0; i < REG_W; i++) begin : g_bit
         // set wins over a software clear in the same cycle
         assign next_flags[i] = implMask[i] & (setEvent[i] |
                                (swWrite & swMask[i] ? swData[i] : flags[i]));
      end
   endgenerate
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FLAG_RESET;
      end else if (ce) begin
         flags <= next_flags;
      end
   end
endmodule

/* src/apb_reg_port.sv */
// apb slave front end: decode, write strobes, address hit
`timescale 1ns/100ps
module apb_reg_port
   import sleep_wake_pkg::*;
(
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   output logic             wrCtrl,
   output logic             wrEnA,
   output logic             wrEnB,
   output logic             wrFlagA,
   output logic             wrFlagB,
   output logic             wrReg,
   output logic             hitAny
);
   wire access = psel & penable & pwrite;
   assign wrCtrl  = access & (paddr == ADDR_CORE_CTRL);
   assign wrEnA   = access & (paddr == ADDR_ENABLE_A);
   assign wrEnB   = access & (paddr == ADDR_ENABLE_B);
   assign wrFlagA = access & (paddr == ADDR_FLAGS_A);
   assign wrFlagB = access & (paddr == ADDR_FLAGS_B);
   assign wrReg   = access & (paddr == ADDR_REGULATOR);
   assign hitAny  = (paddr == ADDR_CORE_CTRL) | (paddr == ADDR_ENABLE_A) | (paddr == ADDR_ENABLE_B)
                  | (paddr == ADDR_FLAGS_A) | (paddr == ADDR_FLAGS_B) | (paddr == ADDR_REGULATOR)
                  | (paddr == ADDR_STATUS);
endmodule

/* bench/sleep_wake_props.sv */
// port assertions for the sleep, wake and flag block
`timescale 1ns/100ps
module sleep_wake_props
   import sleep_wake_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        sleepExec,
   input wire logic        coreClockEnable,
   input wire logic        wakeResume,
   input wire logic        watchdogClear,
   input wire logic        vectorRequest,
   input wire logic [15:0] vectorAddress,
   input wire logic        regulatorLowPower,
   input wire logic        portHold,
   input wire logic        lowFreqOscRun,
   input wire logic        secondaryOscRun
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_APB_ZERO_WAIT: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   AST_SLEEP_BY_INSTR: assert property ($fell(coreClockEnable) |-> $past(sleepExec))
      else $error("clock stopped without sleep instruction");
   AST_ENTRY_WD_CLEAR: assert property ($fell(coreClockEnable) |-> watchdogClear)
      else $error("watchdog not cleared on sleep entry");
   AST_OSC_RUN: assert property (!coreClockEnable |-> lowFreqOscRun && secondaryOscRun)
      else $error("oscillator stopped in sleep");
   AST_HOLD_IN_SLEEP: assert property (portHold |-> !coreClockEnable) else $error("port hold while running");
   AST_REG_LP_SLEEP: assert property (regulatorLowPower |-> !coreClockEnable)
      else $error("regulator low power while running");
   AST_WAKE_WD_CLEAR: assert property (wakeResume |-> watchdogClear) else $error("watchdog kept on wake");
   AST_WAKE_RESUME: assert property (wakeResume |=> coreClockEnable && !wakeResume)
      else $error("core clock not back after wake");
   AST_VECTOR_ADDR: assert property (vectorRequest |-> vectorAddress == 16'h0004 && coreClockEnable)
      else $error("bad vector request");
endmodule

bind sleep_wake_ctrl sleep_wake_props u_props (.mclk, .rst_n, .psel, .penable, .pready, .sleepExec,
   .coreClockEnable, .wakeResume, .watchdogClear, .vectorRequest, .vectorAddress, .regulatorLowPower,
   .portHold, .lowFreqOscRun, .secondaryOscRun);

/* bench/core_periph_model.sv */
// behavioural core and peripherals: sleep, watchdog and flag events
`timescale 1ns/100ps
module core_periph_model (
   input  wire logic mclk,
   output logic      sleepExec,
   output logic      watchdogClearInstr,
   output logic      watchdogTimeout,
   output logic      externalIrq,
   output logic [7:0] eventsA,
   output logic [7:0] eventsB
);
   initial begin
      sleepExec = 1'b0;
      watchdogClearInstr = 1'b0;
      watchdogTimeout = 1'b0;
      externalIrq = 1'b0;
      eventsA = 8'h00;
      eventsB = 8'h00;
   end
   // one-cycle pulses; k is {timeout, clear instruction, sleep}
   task automatic fire(input logic [2:0] k, input logic [7:0] a, input logic [7:0] b);
      sleepExec <= k[0];
      watchdogClearInstr <= k[1];
      watchdogTimeout <= k[2];
      eventsA <= a;
      eventsB <= b;
      @(posedge mclk);
      // idle slot after sleep stands in for a no-op instruction
      sleepExec <= 1'b0;
      watchdogClearInstr <= 1'b0;
      watchdogTimeout <= 1'b0;
      eventsA <= 8'h00;
      eventsB <= 8'h00;
   endtask
   task automatic irq(input logic v);
      externalIrq <= v;
   endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the sleep, wake and flag block
`timescale 1ns/100ps
module testbench import sleep_wake_pkg::*;;
   logic        mclk, rst_n, ce, psel, penable, pwrite, pready, pslverr, lastErr, portHoldNone;
   logic        sleepExec, watchdogClearInstr, watchdogSleepEnable, externalIrq, watchdogTimeout;
   logic        coreClockEnable, wakeResume, vectorRequest, watchdogClear, regulatorLowPower, portHold;
   logic        lowFreqOscRun, secondaryOscRun;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdVal;
   logic [15:0] vectorAddress;
   logic [7:0]  eventsA, eventsB;
   int          failures, checks_done;

   sleep_wake_ctrl u_dut (.mclk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sleepExec, .watchdogClearInstr, .watchdogSleepEnable, .externalIrq, .watchdogTimeout,
      .portHoldNone, .coreClockEnable, .wakeResume, .vectorRequest, .vectorAddress, .watchdogClear,
      .regulatorLowPower, .portHold, .lowFreqOscRun, .secondaryOscRun, .eventsA, .eventsB);
   core_periph_model u_far (.mclk, .sleepExec, .watchdogClearInstr, .watchdogTimeout, .externalIrq,
      .eventsA, .eventsB);

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   task automatic tally_and_finish();
      if (failures == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t bit %b expected %b", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16)
         failures++;
      rdVal = prdata;
      lastErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 32'h0);
      chk32(rdVal, {24'h0, exp});
   endtask

   task automatic waitWake();
      int n;
      n = 0;
      while (wakeResume !== 1'b1 && n < 10) begin
         @(posedge mclk);
         n++;
      end
      chk1(wakeResume, 1'b1);
      repeat (2) @(posedge mclk);
      chk1(coreClockEnable, 1'b1);
   endtask

   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end

   initial begin
      {rst_n, psel, penable, pwrite, portHoldNone, paddr, pwdata} = '0;
      {ce, watchdogSleepEnable} = 2'b11;
      failures = 0;
      checks_done = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(ADDR_CORE_CTRL, 8'h00);
      rd(ADDR_FLAGS_A, 8'h00);
      rd(ADDR_FLAGS_B, 8'h00);
      rd(ADDR_REGULATOR, 8'h01);
      rd(ADDR_STATUS, 8'h18);
      rd(12'h01c, 8'h00);
      chk1(lastErr, 1'b1);
      apb(1'b1, ADDR_FLAGS_A, 32'hff);
      rd(ADDR_FLAGS_A, 8'hcf);
      apb(1'b1, ADDR_FLAGS_B, 32'hff);
      rd(ADDR_FLAGS_B, 8'h89);
      apb(1'b1, ADDR_FLAGS_A, 32'h0);
      apb(1'b1, ADDR_FLAGS_B, 32'h0);
      u_far.fire(3'b000, 8'hff, 8'hff);
      @(posedge mclk);
      rd(ADDR_FLAGS_A, 8'hff);
      rd(ADDR_FLAGS_B, 8'h89);
      apb(1'b1, ADDR_FLAGS_A, 32'h0);
      apb(1'b1, ADDR_FLAGS_B, 32'h0);
      rd(ADDR_FLAGS_A, 8'h30);
      apb(1'b1, ADDR_ENABLE_A, 32'h01);
      apb(1'b1, ADDR_REGULATOR, 32'h02);
      rd(ADDR_REGULATOR, 8'h03);
      u_far.fire(3'b001, 8'h00, 8'h00);
      repeat (2) @(posedge mclk);
      chk1(coreClockEnable, 1'b0);
      chk1(regulatorLowPower, 1'b1);
      chk1(portHold, 1'b1);
      rd(ADDR_STATUS, 8'h11);
      u_far.fire(3'b000, 8'h02, 8'h00);
      repeat (4) @(posedge mclk);
      chk1(coreClockEnable, 1'b0);
      u_far.fire(3'b000, 8'h01, 8'h00);
      waitWake();
      chk1(regulatorLowPower, 1'b0);
      rd(ADDR_STATUS, 8'h10);
      u_far.fire(3'b010, 8'h00, 8'h00);
      @(posedge mclk);
      u_far.fire(3'b001, 8'h00, 8'h00);
      repeat (3) @(posedge mclk);
      chk1(coreClockEnable, 1'b1);
      rd(ADDR_STATUS, 8'h18);
      apb(1'b1, ADDR_CORE_CTRL, 32'h80);
      @(posedge mclk);
      chk1(vectorRequest, 1'b0);
      apb(1'b1, ADDR_CORE_CTRL, 32'hc0);
      @(posedge mclk);
      chk1(vectorRequest, 1'b1);
      chk32({16'h0, vectorAddress}, 32'h0004);
      apb(1'b1, ADDR_CORE_CTRL, 32'h0);
      apb(1'b1, ADDR_FLAGS_A, 32'h0);
      for (int s = 0; s < 2; s++) begin
         u_far.fire(3'b001, 8'h00, 8'h00);
         repeat (3) @(posedge mclk);
         chk1(coreClockEnable, 1'b0);
         if (s == 0)
            u_far.fire(3'b100, 8'h00, 8'h00);
         else
            u_far.irq(1'b1);
         waitWake();
         u_far.irq(1'b0);
         repeat (3) @(posedge mclk);
      end
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rd(ADDR_FLAGS_A, 8'h00);
      rd(ADDR_ENABLE_A, 8'h00);
      tally_and_finish();
   end
endmodule
